// *** common/cpe_pkg.sv ***
// package: constants and carriers for the compare pseudo-op expander
package cpe_pkg;

  localparam int DATA_W = 32;
  localparam int IMM_W  = 16;
  localparam int IDX_W  = 5;

  // increment applied when folding a pseudo immediate into the native field
  localparam logic [15:0] IMM_INC = 16'h0001;

  // compare outcomes as written to the destination
  localparam logic [31:0] RES_TRUE  = 32'h0000_0001;
  localparam logic [31:0] RES_FALSE = 32'h0000_0000;

  // legal immediate ranges, signed and unsigned forms
  localparam int SGN_IMM_MAX = 32766;
  localparam int SGN_IMM_MIN = -32769;
  localparam int UNS_IMM_MAX = 65534;
  localparam int UNS_IMM_MIN = 0;

  // pseudo compares accepted from the decoder
  typedef enum logic [2:0] {
    OP_GTI,
    OP_GTU,
    OP_GTUI,
    OP_LE,
    OP_LEI,
    OP_LEU,
    OP_LEUI
  } cpe_pseudo_e;

  // native compares that carry them out
  typedef enum logic [1:0] {
    NAT_GE,
    NAT_GEU,
    NAT_LT,
    NAT_LTU
  } cpe_native_e;

  typedef struct packed {
    logic              valid;
    cpe_pseudo_e       op;
    logic [31:0]       first_source;
    logic [31:0]       second_source;
    logic [31:0]       given_immediate;
    logic [4:0]        second_source_or_imm_dest;
    logic [4:0]        reg_form_dest;
  } cpe_req_s;

  typedef struct packed {
    logic              valid;
    logic [4:0]        dest;
    logic [31:0]       value;
    cpe_native_e       native;
    logic [15:0]       encoded_immediate_field;
  } cpe_res_s;

endpackage

// *** src/cpe_compare.sv ***
// design: greater-than / less-or-equal pseudo compares mapped to natives
// Overview of operation
// [RULE1] signed gt-immediate: sign-extend immediate, write 1 if first source greater
// [RULE2] software keeps signed gt-immediate within -32769 to 32766
// [RULE3] immediate forms use native ge/lt with field equal immediate plus one
// [RULE4] unsigned gt register: write 1 if first source exceeds second source
// [RULE5] unsigned gt-immediate: zero-extend immediate, write 1 if first source greater
// [RULE6] software keeps unsigned immediate forms within 0 to 65534
// [RULE7] signed le register: write 1 if first source not above second source
// [RULE8] signed le-immediate: sign-extend immediate, write 1 if first source not above
// [RULE9] software keeps signed le-immediate within -32769 to 32766
// [RULE10] unsigned le register: write 1 if first source not above second
// [RULE11] unsigned le-immediate: write 1 if first source not above zero-extended immediate
// [RULE12] register forms swap operands of native ltu, ge or geu
// [RULE13] native immediate is a 16-bit field extended before comparing
// [RULE14] destination gets zeros above bit zero, written in the alu slot
`timescale 1ns/1ps

module cpe_compare
(
  // clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // request from the decoder
  input  wire cpe_pkg::cpe_req_s req_i,
  // result toward the register file
  output cpe_pkg::cpe_res_s      res_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] sext16(input logic [15:0] f);
    sext16 = {{16{f[15]}}, f};
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] f);
    zext16 = {16'h0000, f};
  endfunction

  function automatic logic native_cmp(input cpe_pkg::cpe_native_e n,
                                      input logic [31:0] a,
                                      input logic [31:0] b);
    case (n)
      cpe_pkg::NAT_GE:  native_cmp = $signed(a) >= $signed(b);
      cpe_pkg::NAT_GEU: native_cmp = a >= b;
      cpe_pkg::NAT_LT:  native_cmp = $signed(a) < $signed(b);
      cpe_pkg::NAT_LTU: native_cmp = a < b;
      default:          native_cmp = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // mapping of pseudo to native
  logic [15:0]         enc_field;
  cpe_pkg::cpe_native_e nxt_native;
  logic [31:0]         opnd_a;
  logic [31:0]         opnd_b;
  logic [4:0]          nxt_dest;
  logic                op_legal;
  logic                outcome;
  cpe_pkg::cpe_res_s   res_ff;
  cpe_pkg::cpe_res_s   nxt_res;

  // wraps at 16 bits; legal ranges keep the sum representable
  assign enc_field = req_i.given_immediate[15:0] + cpe_pkg::IMM_INC; // see [RULE3]

  always_comb
  begin
    nxt_native = cpe_pkg::NAT_GE;
    opnd_a     = req_i.first_source;
    opnd_b     = req_i.second_source;
    nxt_dest   = req_i.reg_form_dest;
    op_legal   = 1'b1;
    case (req_i.op)
      cpe_pkg::OP_GTI:
      begin
        nxt_native = cpe_pkg::NAT_GE; // see [RULE3]
        opnd_b     = sext16(enc_field); // see [RULE13]
        nxt_dest   = req_i.second_source_or_imm_dest;
      end
      cpe_pkg::OP_GTUI:
      begin
        nxt_native = cpe_pkg::NAT_GEU; // see [RULE3]
        opnd_b     = zext16(enc_field); // see [RULE13]
        nxt_dest   = req_i.second_source_or_imm_dest;
      end
      cpe_pkg::OP_LEI:
      begin
        nxt_native = cpe_pkg::NAT_LT; // see [RULE3]
        opnd_b     = sext16(enc_field); // see [RULE13]
        nxt_dest   = req_i.second_source_or_imm_dest;
      end
      cpe_pkg::OP_LEUI:
      begin
        nxt_native = cpe_pkg::NAT_LTU; // see [RULE3]
        opnd_b     = zext16(enc_field); // see [RULE13]
        nxt_dest   = req_i.second_source_or_imm_dest;
      end
      cpe_pkg::OP_GTU:
      begin
        nxt_native = cpe_pkg::NAT_LTU; // see [RULE12]
        opnd_a     = req_i.second_source;
        opnd_b     = req_i.first_source;
      end
      cpe_pkg::OP_LE:
      begin
        nxt_native = cpe_pkg::NAT_GE; // see [RULE12]
        opnd_a     = req_i.second_source;
        opnd_b     = req_i.first_source;
      end
      cpe_pkg::OP_LEU:
      begin
        nxt_native = cpe_pkg::NAT_GEU; // see [RULE12]
        opnd_a     = req_i.second_source;
        opnd_b     = req_i.first_source;
      end
      default:
      begin
        // unused code: no write, so a stray encoding cannot clobber a register
        op_legal = 1'b0;
      end
    endcase
  end

  assign outcome = native_cmp(nxt_native, opnd_a, opnd_b);

  always_comb
  begin
    nxt_res                         = '0;
    nxt_res.valid                   = req_i.valid && op_legal;
    nxt_res.dest                    = nxt_dest;
    nxt_res.native                  = nxt_native;
    nxt_res.encoded_immediate_field = enc_field;
    nxt_res.value = outcome ? cpe_pkg::RES_TRUE : cpe_pkg::RES_FALSE; // see [RULE14]
  end

  ////////////////////////////////////////////////////////////////////////////
  // one-cycle result register, same slot as other alu results
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      res_ff <= '0;
    else
      res_ff <= nxt_res; // see [RULE14]
  end

  assign res_o = res_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks: previous request kept for comparison against the result
  cpe_pkg::cpe_req_s prv_ff;
  logic              sgn_ok;
  logic              uns_ok;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      prv_ff <= '0;
    else
      prv_ff <= req_i;
  end

  // outside the legal range the +1 field wraps; results are not checked there
  assign sgn_ok = ($signed(prv_ff.given_immediate) <= cpe_pkg::SGN_IMM_MAX) &&
                  ($signed(prv_ff.given_immediate) >= cpe_pkg::SGN_IMM_MIN);
  assign uns_ok = (prv_ff.given_immediate <= cpe_pkg::UNS_IMM_MAX);

  gti_result_a: // see [RULE1] [RULE2]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_GTI && sgn_ok |->
    res_ff.value == {31'h0, $signed(prv_ff.first_source) >
                            $signed(prv_ff.given_immediate)})
  else $error("signed gt-immediate result wrong");

  imm_field_a: // see [RULE3]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    req_i.valid && req_i.op == cpe_pkg::OP_LEUI |=>
    res_ff.native == cpe_pkg::NAT_LTU &&
    res_ff.encoded_immediate_field ==
      $past(req_i.given_immediate[15:0]) + 16'h0001 &&
    res_ff.dest == $past(req_i.second_source_or_imm_dest))
  else $error("immediate form not folded into native field");

  gtu_result_a: // see [RULE4]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_GTU |->
    res_ff.value[0] == (prv_ff.first_source > prv_ff.second_source))
  else $error("unsigned gt register result wrong");

  gtui_result_a: // see [RULE5] [RULE6]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_GTUI && uns_ok |->
    res_ff.value[0] == (prv_ff.first_source > prv_ff.given_immediate))
  else $error("unsigned gt-immediate result wrong");

  le_result_a: // see [RULE7]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_LE |->
    res_ff.value[0] == ($signed(prv_ff.first_source) <=
                        $signed(prv_ff.second_source)))
  else $error("signed le register result wrong");

  lei_result_a: // see [RULE8] [RULE9]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_LEI && sgn_ok |->
    res_ff.value[0] == ($signed(prv_ff.first_source) <=
                        $signed(prv_ff.given_immediate)))
  else $error("signed le-immediate result wrong");

  leu_result_a: // see [RULE10]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_LEU |->
    res_ff.value[0] == (prv_ff.first_source <= prv_ff.second_source))
  else $error("unsigned le register result wrong");

  leui_result_a: // see [RULE11] [RULE6]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid && prv_ff.op == cpe_pkg::OP_LEUI && uns_ok |->
    res_ff.value[0] == (prv_ff.first_source <= prv_ff.given_immediate))
  else $error("unsigned le-immediate result wrong");

  reg_swap_map_a: // see [RULE12]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    req_i.valid && req_i.op == cpe_pkg::OP_LE |=>
    res_ff.native == cpe_pkg::NAT_GE &&
    res_ff.dest == $past(req_i.reg_form_dest))
  else $error("signed le register not mapped to swapped ge");

  sign_extend_a: // see [RULE13]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    req_i.valid && req_i.op == cpe_pkg::OP_LEI &&
    req_i.given_immediate == 32'hFFFF_8000 &&
    $signed(req_i.first_source) < 0 |=> res_ff.value == 32'h0000_0001)
  else $error("immediate field not sign extended");

  upper_zero_a: // see [RULE14]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    res_ff.valid |-> res_ff.value[31:1] == 31'h0)
  else $error("result upper bits not zero");

  one_slot_a: // see [RULE14]
  assert property (@(posedge clk_sys) disable iff (!reset_n)
    req_i.valid && req_i.op != 3'h7 |=> res_ff.valid ##1 1'b1)
  else $error("result not written one cycle after request");

endmodule

// *** testbench/compare_pseudo_op_expander_tb_top.sv ***
// testbench: directed checks of the compare pseudo-op expander
`timescale 1ns/1ps

module compare_pseudo_op_expander_tb_top;
  // clock, reset and design ports
  logic              clk_sys   = 1'b0;
  logic              reset_n   = 1'b0;
  cpe_pkg::cpe_req_s req_i     = '0;
  cpe_pkg::cpe_res_s res_o;
  // expected result, one stage per cycle of latency
  cpe_pkg::cpe_res_s exp_a     = '0;
  cpe_pkg::cpe_res_s exp_b     = '0;
  int                err_count = 0;
  int                tests_run = 0;
  logic [4:0]        seq_n     = 5'h00;

  localparam int S_MIN = cpe_pkg::SGN_IMM_MIN;
  localparam int S_MAX = cpe_pkg::SGN_IMM_MAX;
  localparam int U_MIN = cpe_pkg::UNS_IMM_MIN;
  localparam int U_MAX = cpe_pkg::UNS_IMM_MAX;

  always #2.5 clk_sys = ~clk_sys;

  cpe_compare uut
  (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .req_i   (req_i),
    .res_o   (res_o)
  );

////////////////////////////////////////////////////////////////////////////
  // reference from the pseudo meaning, not from the native mapping
  function automatic cpe_pkg::cpe_res_s model(
    input cpe_pkg::cpe_pseudo_e op, input logic [31:0] a, b, imm,
    input logic [4:0] dn);
    cpe_pkg::cpe_res_s r;
    logic              t;
    r = '0;
    t = 1'b0;
    r.valid = 1'b1;
    r.dest = dn;
    r.encoded_immediate_field = imm[15:0] + cpe_pkg::IMM_INC;
    case (op)
      cpe_pkg::OP_GTI:  t = $signed(a) > $signed(imm);
      cpe_pkg::OP_GTU:  t = a > b;
      cpe_pkg::OP_GTUI: t = a > imm;
      cpe_pkg::OP_LE:   t = $signed(a) <= $signed(b);
      cpe_pkg::OP_LEI:  t = $signed(a) <= $signed(imm);
      cpe_pkg::OP_LEU:  t = a <= b;
      cpe_pkg::OP_LEUI: t = a <= imm;
      default:          r.valid = 1'b0;
    endcase
    case (op)
      cpe_pkg::OP_GTI, cpe_pkg::OP_LE:   r.native = cpe_pkg::NAT_GE;
      cpe_pkg::OP_GTUI, cpe_pkg::OP_LEU: r.native = cpe_pkg::NAT_GEU;
      cpe_pkg::OP_LEI:                   r.native = cpe_pkg::NAT_LT;
      default:                           r.native = cpe_pkg::NAT_LTU;
    endcase
    r.value = t ? cpe_pkg::RES_TRUE : cpe_pkg::RES_FALSE;
    return r;
  endfunction

  // called at a rising edge; the unused dest field gets the inverse index
  task automatic issue(input cpe_pkg::cpe_pseudo_e op,
                       input logic [31:0] a, b, imm);
    logic rf;
    rf = op inside {cpe_pkg::OP_GTU, cpe_pkg::OP_LE, cpe_pkg::OP_LEU};
    seq_n = seq_n + 5'h01;
    req_i <= '{valid: 1'b1, op: op, first_source: a, second_source: b,
               given_immediate: imm,
               second_source_or_imm_dest: rf ? ~seq_n : seq_n,
               reg_form_dest: rf ? seq_n : ~seq_n};
    exp_a <= model(op, a, b, imm, seq_n);
    @(posedge clk_sys);
  endtask

  task automatic idle;
    req_i <= '0;
    exp_a <= '0;
    @(posedge clk_sys);
  endtask

  task automatic chk_res(input cpe_pkg::cpe_res_s want, got);
    tests_run = tests_run + 1;
    if (want.valid ? (got !== want) : (got.valid !== 1'b0))
    begin
      err_count = err_count + 1;
      $display("unexpected %0t result %h want %h", $time, got, want);
    end
  endtask

  // one edge of latency, judged mid-cycle where the result is settled
  always @(posedge clk_sys) exp_b <= exp_a;
  always @(negedge clk_sys)
    if (reset_n)
      chk_res(exp_b, res_o);

////////////////////////////////////////////////////////////////////////////
  task automatic t_walk;
    issue(cpe_pkg::OP_LEI, 32'h5, 32'h0, 32'h5);
    issue(cpe_pkg::OP_GTU, 32'h3, 32'h2, 32'h0);
  endtask

  // first source one below, at and one above each range end
  task automatic sweep(input cpe_pkg::cpe_pseudo_e op, input int lo, hi);
    logic [31:0] v;
    logic [31:0] a;
    for (int i = 0; i < 6; i++)
    begin
      v = (i < 3) ? 32'(lo) : 32'(hi);
      a = v + 32'(i % 3) - 32'h1;
      issue(op, a, ~a, v);
    end
  endtask

  task automatic t_imm;
    sweep(cpe_pkg::OP_GTI, S_MIN, S_MAX);
    sweep(cpe_pkg::OP_GTUI, U_MIN, U_MAX);
    sweep(cpe_pkg::OP_LEI, S_MIN, S_MAX);
    sweep(cpe_pkg::OP_LEUI, U_MIN, U_MAX);
  endtask

  // sign boundary pairs split signed from unsigned meaning
  task automatic t_reg;
    logic [31:0] a [6];
    logic [31:0] b [6];
    a = '{32'h3, 32'h2, 32'h5, 32'hFFFF_FFFF, 32'h1, 32'h8000_0000};
    b = '{32'h2, 32'h3, 32'h5, 32'h1, 32'hFFFF_FFFF, 32'h7FFF_FFFF};
    for (int i = 0; i < 6; i++)
    begin
      issue(cpe_pkg::OP_GTU, a[i], b[i], a[i]);
      issue(cpe_pkg::OP_LE, a[i], b[i], b[i]);
      issue(cpe_pkg::OP_LEU, a[i], b[i], ~b[i]);
    end
  endtask

  // unused code between live ones must not write
  task automatic t_bad;
    issue(cpe_pkg::OP_GTI, 32'h10, 32'h0, 32'h10);
    issue(cpe_pkg::cpe_pseudo_e'(3'h7), 32'h10, 32'h0, 32'h0);
    idle;
    issue(cpe_pkg::OP_LEUI, 32'hFFFF_FFFF, 32'h0, 32'hFFFE);
  endtask

////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_walk;
    t_imm;
    t_reg;
    t_bad;
    idle;
    idle;
    summarize;
  end

  // cuts a hang short
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count = err_count + 1;
    $display("unexpected %0t run did not finish", $time);
    summarize;
  end
endmodule
